/* core/adcms_top.sv */
// Purpose: Operating mode and conversion control of a delta-sigma converter.
// Assumes: Serial clock is idle low; the filter datapath reports conv_done.
// Notes:   Serial decode and the rising-edge flag run on sclk; everything else runs on core_clk.
`timescale 1ns/1ps
`default_nettype none

module adcms_top #(
  parameter int MOD_PERIOD_CYCLES = adcms_pkg::MOD_PERIOD_CLKS
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  input  wire logic       trig_pin,
  input  wire logic       conv_single,
  input  wire logic       use_high_order_filter,
  input  wire logic [2:0] delay_sel,
  input  wire logic       cfg_settle_wr,
  input  wire logic       conv_done,
  input  wire logic       ext_clk_req,
  output var  logic       data_ready_n,
  output var  logic       serial_out_ready_pin_o,
  output var  logic       serial_out_ready_pin_oe_n,
  output var  logic       analog_on,
  output var  logic       core_clk_en,
  output var  logic       mod_clk_en,
  output var  logic       filter_reset,
  output var  logic       conv_run,
  output var  logic       cfg_reset,
  output var  logic       int_osc_sel,
  output var  logic       register_read_cmd,
  output var  logic       register_write_cmd,
  output var  logic       data_read_cmd,
  output var  logic       cal_cmd
);
  import adcms_pkg::*;

  // ==========================================================
  // Serial link, sampled on falling sclk
  // ==========================================================
  typedef struct packed {
    logic [2:0] cnt;
    logic [5:0] sh;
    logic [6:0] cmd;
    logic       tgl;
  } adcms_link_t;

  adcms_link_t lk_q;
  adcms_link_t lk_d;
  logic        rise_tgl_q;

  // The command word stays put from its decode until the next decode or a
  // chip-select release. The core reads it only once the toggle has passed its
  // synchroniser, so the word is settled by then.
  always_comb begin
    lk_d     = lk_q;
    lk_d.sh  = {lk_q.sh[4:0], din};
    lk_d.cnt = lk_q.cnt + 3'h1;
    if (lk_q.cnt == BIT_DECODE_IDX) begin
      lk_d.cmd = {lk_q.sh, din};
      lk_d.tgl = ~lk_q.tgl;
    end
  end

  // Data is taken on the falling edge, the second edge of mode 1.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // Every rising serial clock while chip select is low flips this flag; the core turns each flip into
  // one clearing event for the ready output.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_tgl_q <= 1'b0;
    end else begin
      rise_tgl_q <= ~rise_tgl_q;
    end
  end

  // ==========================================================
  // Core state
  // ==========================================================
  typedef struct packed {
    logic         cs_s1;
    logic         cs_s2;
    logic         tg_s1;
    logic         tg_s2;
    logic         tg_s3;
    logic         rs_s1;
    logic         rs_s2;
    logic         rs_s3;
    logic         tp_s1;
    logic         tp_s2;
    logic         tp_s3;
    adcms_state_t st;
    adcms_act_t   pact;
    logic [1:0]   pcnt;
    logic         stop_pend;
    logic [16:0]  dly;
    logic [1:0]   conv_cnt;
    logic         data_ready_n_n;
    logic         pin_oe_n;
    logic         analog_on;
    logic         core_clk_en;
    logic         mod_clk_en;
    logic         filter_reset;
    logic         conv_run;
    logic         cfg_reset;
    logic         int_osc;
    logic         reg_rd;
    logic         reg_wr;
    logic         data_rd;
    logic         cal;
  } adcms_core_t;

  // The synchronised chip select starts high so that the shared pin stays
  // released until the host really selects the device.
  localparam adcms_core_t CORE_RST = '{
    st: ST_STANDBY, pact: ACT_NONE, data_ready_n_n: 1'b1, pin_oe_n: 1'b1,
    cs_s1: 1'b1, cs_s2: 1'b1, analog_on: 1'b1, core_clk_en: 1'b1,
    filter_reset: 1'b1, cfg_reset: 1'b1, int_osc: 1'b1, default: '0
  };

  adcms_core_t q;
  adcms_core_t n;

  function automatic logic [16:0] settle_cycles(input logic [2:0] s);
    logic [31:0] p;
    p = 32'(adcms_delay_mods(s)) * 32'(MOD_PERIOD_CYCLES);
    return p[16:0];
  endfunction

  logic       cmd_evt;
  logic       sclk_rise;
  logic       trig_rise;
  logic       trig_fall;
  adcms_cls_t cls;
  adcms_act_t act;

  always_comb begin
    n           = q;
    n.cfg_reset = 1'b0;
    n.reg_rd    = 1'b0;
    n.reg_wr    = 1'b0;
    n.data_rd   = 1'b0;
    n.cal       = 1'b0;
    act         = ACT_NONE;

    // Pins and link flags pass two flip-flops before any decision reads them.
    n.cs_s1 = cs_n;
    n.cs_s2 = q.cs_s1;
    n.tg_s1 = lk_q.tgl;
    n.tg_s2 = q.tg_s1;
    n.tg_s3 = q.tg_s2;
    n.rs_s1 = rise_tgl_q;
    n.rs_s2 = q.rs_s1;
    n.rs_s3 = q.rs_s2;
    n.tp_s1 = trig_pin;
    n.tp_s2 = q.tp_s1;
    n.tp_s3 = q.tp_s2;

    // Toggles dropping back on chip-select release are not commands.
    cmd_evt   = (q.tg_s2 ^ q.tg_s3) & ~q.cs_s2;
    sclk_rise = (q.rs_s2 ^ q.rs_s3) & ~q.cs_s2;
    trig_rise = q.tp_s2 & ~q.tp_s3;
    trig_fall = ~q.tp_s2 & q.tp_s3;
    cls       = cmd_evt ? adcms_cmd_class(lk_q.cmd) : CL_NONE;

    // Delayed actions fire two clocks after they are seen.
    if (q.pcnt != 2'h0) begin
      n.pcnt = q.pcnt - 2'h1;
      if (q.pcnt == 2'h1) begin
        act = q.pact;
      end
    end

    // A new start, stop or trigger edge replaces any pending one.
    // A pending power-down is never displaced by a later start or stop.
    if (cls == CL_ENTER_SLEEP) begin
      n.pact = ACT_SLEEP;
      n.pcnt = CMD_EFFECT_CYCLES;
    end else if (q.pact == ACT_SLEEP && q.pcnt != 2'h0) begin
      n.pact = ACT_SLEEP;
    end else if (cls == CL_START && q.st != ST_SLEEP) begin
      n.pact = ACT_START;
      n.pcnt = CMD_EFFECT_CYCLES;
    end else if (cls == CL_STOP && q.st != ST_SLEEP) begin
      n.pact = ACT_STOP;
      n.pcnt = CMD_EFFECT_CYCLES;
    end else if (trig_rise && q.st != ST_SLEEP) begin
      n.pact = ACT_START;
      n.pcnt = CMD_EFFECT_CYCLES;
    end else if (trig_fall && q.st != ST_SLEEP) begin
      n.pact = ACT_STOP;
      n.pcnt = CMD_EFFECT_CYCLES;
    end

    // The state walk runs first; a delayed action that fires in the same cycle
    // then takes precedence over it.
    case (q.st)
      ST_SETTLE: begin
        if (q.dly <= 17'h00001) begin
          n.st = ST_CONVERT;
        end else begin
          n.dly = q.dly - 17'h00001;
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          if (conv_single) begin
            if (use_high_order_filter && q.conv_cnt < HIGH_ORDER_N - 2'h1) begin
              n.conv_cnt = q.conv_cnt + 2'h1;
            end else begin
              n.data_ready_n_n = 1'b0;
              n.st     = ST_STANDBY;
            end
          end else begin
            n.data_ready_n_n = 1'b0;
            if (q.stop_pend) begin
              n.st        = ST_STANDBY;
              n.stop_pend = 1'b0;
            end
          end
        end
      end
      ST_SLEEP, ST_STANDBY: begin
      end
      default: begin
        n.st = ST_STANDBY;
      end
    endcase

    // Actions come after the state walk so that a restart loads a fresh delay
    // and a power-down is not undone by a result that lands in the same cycle.
    // A stop that meets a result still arms the stop for the next result.
    case (act)
      ACT_SLEEP: begin
        n.st        = ST_SLEEP;
        n.stop_pend = 1'b0;
      end
      ACT_START: begin
        if (q.st != ST_SLEEP) begin
          n.st        = ST_SETTLE;
          n.dly       = settle_cycles(delay_sel);
          n.conv_cnt  = 2'h0;
          n.stop_pend = 1'b0;
        end
      end
      ACT_STOP: begin
        if (q.st == ST_SETTLE) begin
          n.st = ST_STANDBY;
        end else if (q.st == ST_CONVERT && !conv_single) begin
          n.stop_pend = 1'b1;
        end
      end
      default: begin
      end
    endcase

    // A configuration write while converting restarts the settling.
    if (cfg_settle_wr && (q.st == ST_SETTLE || q.st == ST_CONVERT) && act == ACT_NONE) begin
      n.st       = ST_SETTLE;
      n.dly      = settle_cycles(delay_sel);
      n.conv_cnt = 2'h0;
    end

    case (cls)
      CL_EXIT_SLEEP: begin
        if (q.st == ST_SLEEP) begin
          n.st = ST_STANDBY;
        end
      end
      CL_RESET: begin
        if (q.st != ST_SLEEP) begin
          n.st        = ST_STANDBY;
          n.cfg_reset = 1'b1;
          n.int_osc   = 1'b1;
          n.pact      = ACT_NONE;
          n.pcnt      = 2'h0;
          n.stop_pend = 1'b0;
          n.data_ready_n_n    = 1'b1;
        end
      end
      CL_REG_READ:  n.reg_rd  = 1'b1;
      CL_DATA_READ: n.data_rd = 1'b1;
      CL_REG_WRITE: n.reg_wr  = (q.st != ST_SLEEP);
      CL_CAL:       n.cal     = (q.st == ST_SETTLE || q.st == ST_CONVERT);
      default: begin
      end
    endcase

    // A fresh result outranks a same-cycle clearing edge only while ready is high; with ready already low the clearing edge wins.
    if ((sclk_rise || trig_rise) && n.data_ready_n_n == q.data_ready_n_n) begin
      n.data_ready_n_n = 1'b1;
    end

    // A reset command outside sleep selects the internal oscillator for one clock;
    // while ext_clk_req stays high the next clock deselects it again.
    if (ext_clk_req && cls != CL_RESET) begin
      n.int_osc = 1'b0;
    end else if (!ext_clk_req) begin
      n.int_osc = 1'b1;
    end

    // Power and clock controls follow the next state, so they change on the
    // same edge as the state itself.
    n.analog_on    = (n.st != ST_SLEEP);
    n.core_clk_en  = (n.st == ST_SETTLE || n.st == ST_CONVERT);
    n.mod_clk_en   = (n.st == ST_SETTLE || n.st == ST_CONVERT);
    n.filter_reset = (n.st != ST_CONVERT);
    n.conv_run     = (n.st == ST_CONVERT);
    n.pin_oe_n     = q.cs_s2;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      q <= CORE_RST;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // The shared pin carries the ready level whenever it is driven.
  assign data_ready_n              = q.data_ready_n_n;
  assign serial_out_ready_pin_o    = q.data_ready_n_n;
  assign serial_out_ready_pin_oe_n = q.pin_oe_n;
  assign analog_on                 = q.analog_on;
  assign core_clk_en               = q.core_clk_en;
  assign mod_clk_en                = q.mod_clk_en;
  assign filter_reset              = q.filter_reset;
  assign conv_run                  = q.conv_run;
  assign cfg_reset                 = q.cfg_reset;
  assign int_osc_sel               = q.int_osc;
  assign register_read_cmd         = q.reg_rd;
  assign register_write_cmd        = q.reg_wr;
  assign data_read_cmd             = q.data_rd;
  assign cal_cmd                   = q.cal;

endmodule // adcms_top

`default_nettype wire

/* shared/adcms_pkg.sv */
// Purpose: Shared constants and types for the ADC mode sequencer.
// Assumes: Core clock of 25 MHz; serial clock from the host.
// Notes:   Command codes are kept as their upper seven bits.
package adcms_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int          CORE_CLK_MHZ       = 25;
  localparam int          MOD_PERIOD_CLKS    = 16;
  localparam logic [1:0]  CMD_EFFECT_CYCLES  = 2'h2;
  localparam logic [1:0]  HIGH_ORDER_N       = 2'h3;
  localparam logic [2:0]  BIT_DECODE_IDX     = 3'h6;

  // ==========================================================
  // Command codes, low bit dropped
  // ==========================================================
  localparam logic [6:0]  CMD_EXIT_SLEEP     = 7'h01;
  localparam logic [6:0]  CMD_ENTER_SLEEP    = 7'h02;
  localparam logic [6:0]  CMD_RESET          = 7'h03;
  localparam logic [6:0]  CMD_START          = 7'h04;
  localparam logic [6:0]  CMD_STOP           = 7'h05;
  localparam logic [6:0]  CMD_DATA_READ      = 7'h09;
  localparam logic [6:0]  CMD_SYS_OFFSET_CAL = 7'h0B;
  localparam logic [6:0]  CMD_SELF_OFS_CAL   = 7'h0C;
  localparam logic [2:0]  CMD_REG_READ_TOP   = 3'h1;
  localparam logic [2:0]  CMD_REG_WRITE_TOP  = 3'h2;

  // ==========================================================
  // Settling delay table, in modulator periods
  // ==========================================================
  localparam logic [12:0] DLY_SEL0 = 13'h000E;
  localparam logic [12:0] DLY_SEL1 = 13'h0001;
  localparam logic [12:0] DLY_SEL2 = 13'h0004;
  localparam logic [12:0] DLY_SEL3 = 13'h0010;
  localparam logic [12:0] DLY_SEL4 = 13'h0040;
  localparam logic [12:0] DLY_SEL5 = 13'h0100;
  localparam logic [12:0] DLY_SEL6 = 13'h0400;
  localparam logic [12:0] DLY_SEL7 = 13'h1000;

  typedef enum logic [3:0] {
    ST_SLEEP   = 4'h1,
    ST_STANDBY = 4'h2,
    ST_SETTLE  = 4'h4,
    ST_CONVERT = 4'h8
  } adcms_state_t;

  typedef enum logic [3:0] {
    CL_NONE, CL_EXIT_SLEEP, CL_ENTER_SLEEP, CL_RESET, CL_START,
    CL_STOP, CL_DATA_READ, CL_CAL, CL_REG_READ, CL_REG_WRITE
  } adcms_cls_t;

  typedef enum logic [1:0] {
    ACT_NONE, ACT_START, ACT_STOP, ACT_SLEEP
  } adcms_act_t;

  function automatic adcms_cls_t adcms_cmd_class(input logic [6:0] c);
    adcms_cls_t r;
    r = CL_NONE;
    case (c)
      CMD_EXIT_SLEEP:     r = CL_EXIT_SLEEP;
      CMD_ENTER_SLEEP:    r = CL_ENTER_SLEEP;
      CMD_RESET:          r = CL_RESET;
      CMD_START:          r = CL_START;
      CMD_STOP:           r = CL_STOP;
      CMD_DATA_READ:      r = CL_DATA_READ;
      CMD_SYS_OFFSET_CAL: r = CL_CAL;
      CMD_SELF_OFS_CAL:   r = CL_CAL;
      default: begin
        if (c[6:4] == CMD_REG_READ_TOP) begin
          r = CL_REG_READ;
        end else if (c[6:4] == CMD_REG_WRITE_TOP) begin
          r = CL_REG_WRITE;
        end
      end
    endcase
    return r;
  endfunction

  function automatic logic [12:0] adcms_delay_mods(input logic [2:0] s);
    logic [12:0] m;
    m = DLY_SEL0;
    case (s)
      3'h1:    m = DLY_SEL1;
      3'h2:    m = DLY_SEL2;
      3'h3:    m = DLY_SEL3;
      3'h4:    m = DLY_SEL4;
      3'h5:    m = DLY_SEL5;
      3'h6:    m = DLY_SEL6;
      3'h7:    m = DLY_SEL7;
      default: m = DLY_SEL0;
    endcase
    return m;
  endfunction

endpackage

/* testbench/adc_mode_sequencer_tb.sv */
// Purpose: Self-checking bench for the ADC mode sequencer.
// Assumes: Modulator period shortened to two core clocks.
// Notes:   Inputs other than the host model's serial pins change on the falling core clock edge.
`timescale 1ns/1ps
`default_nettype none
module adc_mode_sequencer_tb;
  import adcms_pkg::*;
  localparam logic [15:0] MODP = 16'h0002;
  logic core_clk, rst_n, sclk, cs_n, din, trig_pin, conv_single, use_high_order_filter;
  logic cfg_settle_wr, conv_done, ext_clk_req, data_ready_n, serial_out_ready_pin_o;
  logic serial_out_ready_pin_oe_n, analog_on, core_clk_en, mod_clk_en, filter_reset;
  logic conv_run, cfg_reset, int_osc_sel, register_read_cmd, register_write_cmd;
  logic data_read_cmd, cal_cmd;
  logic [2:0]  delay_sel;
  logic [15:0] n_rd = 0, n_wr = 0, n_cal = 0, n_rst = 0, n_drd = 0, n_osc = 0, sa, sb;
  logic        run_q = 1'b0;
  int          fails = 0, samples_checked = 0;

  adcms_top #(.MOD_PERIOD_CYCLES(2)) u_adcms_top (.*);
  adcms_host_model u_adcms_host_model (.sclk, .cs_n, .din);

  always #20 core_clk = ~core_clk;
  // Counting starts one edge after reset so the reset level of cfg_reset is not counted.
  always @(posedge core_clk) begin
    run_q <= rst_n;
    if (rst_n && run_q) begin
      n_rd  <= n_rd + register_read_cmd;
      n_drd <= n_drd + data_read_cmd;
      n_osc <= n_osc + int_osc_sel;
      n_wr  <= n_wr + register_write_cmd;
      n_cal <= n_cal + cal_cmd;
      n_rst <= n_rst + cfg_reset;
    end
  end

  // ====================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] b);
    u_adcms_host_model.frame({8'h00, b}, 1, 1'b0);
    cyc(8);
  endtask
  task automatic wait_run(input logic v);
    for (int i = 0; i < 200 && conv_run !== v; i++) cyc(1);
  endtask
  task automatic done;
    conv_done = 1'b1;
    cyc(1);
    conv_done = 1'b0;
    cyc(2);
  endtask
  task automatic settle_len(input logic [2:0] s, output logic [15:0] n);
    delay_sel = s;
    cfg_settle_wr = 1'b1;
    cyc(1);
    cfg_settle_wr = 1'b0;
    cyc(3);
    n = 0;
    for (int i = 0; i < 300 && conv_run !== 1'b1; i++) begin
      n++;
      cyc(1);
    end
  endtask
  task automatic give_verdict;
    $display("checked %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ====================================
  // Scenarios
  task automatic t_reset;
    chk({data_ready_n, analog_on, int_osc_sel, conv_run, filter_reset}, 16'h001D);
    chk({mod_clk_en, core_clk_en, serial_out_ready_pin_oe_n}, 16'h0001);
  endtask
  task automatic t_cont;
    conv_single = 1'b0;
    cmd({CMD_SYS_OFFSET_CAL, 1'b0});
    chk(n_cal, 16'h0000);
    cmd({CMD_START, 1'b1});
    wait_run(1'b1);
    chk(conv_run, 1'b1);
    cmd({CMD_SELF_OFS_CAL, 1'b1});
    chk(n_cal, 16'h0001);
    done;
    chk({data_ready_n, conv_run}, 16'h0001);
    chk(serial_out_ready_pin_o, 1'b0);
    cmd(8'h00);
    chk(data_ready_n, 1'b1);
    settle_len(3'h2, sa);
    settle_len(3'h0, sb);
    chk(sb - sa, (16'h000E - 16'h0004) * MODP);
    u_adcms_host_model.frame({CMD_STOP, 1'b0, CMD_START, 1'b0}, 2, 1'b0);
    cyc(8);
    chk({conv_run, mod_clk_en}, 16'h0001);
    wait_run(1'b1);
    cmd({CMD_STOP, 1'b0});
    chk(conv_run, 1'b1);
    done;
    chk({data_ready_n, conv_run, mod_clk_en}, 16'h0000);
  endtask
  task automatic t_single;
    conv_single = 1'b1;
    trig_pin = 1'b1;
    wait_run(1'b1);
    done;
    chk({data_ready_n, conv_run}, 16'h0000);
    trig_pin = 1'b0;
    use_high_order_filter = 1'b1;
    cyc(4);
    trig_pin = 1'b1;
    cyc(8);
    chk(data_ready_n, 1'b1);
    wait_run(1'b1);
    done;
    done;
    chk({data_ready_n, conv_run}, 16'h0003);
    done;
    chk({data_ready_n, conv_run}, 16'h0000);
    trig_pin = 1'b0;
    cyc(6);
  endtask
  task automatic t_sleep;
    ext_clk_req = 1'b0;
    cmd({CMD_ENTER_SLEEP, 1'b1});
    chk(analog_on, 1'b0);
    cmd(8'h40);
    chk(n_wr, 16'h0000);
    cmd(8'h20);
    chk(n_rd, 16'h0001);
    cmd({CMD_DATA_READ, 1'b0});
    chk(n_drd, 16'h0001);
    cmd({CMD_RESET, 1'b0});
    chk(n_rst, 16'h0000);
    cmd({CMD_EXIT_SLEEP, 1'b1});
    chk({analog_on, conv_run}, 16'h0002);
    cmd(8'h41);
    chk(n_wr, 16'h0001);
  endtask
  task automatic t_reset_cmd;
    ext_clk_req = 1'b1;
    cmd({CMD_START, 1'b0});
    wait_run(1'b1);
    chk({int_osc_sel, conv_run}, 16'h0001);
    sa = n_osc;
    cmd({CMD_RESET, 1'b1});
    chk(n_rst, 16'h0001);
    chk(n_osc != sa, 1'b1);
    ext_clk_req = 1'b0;
    cyc(2);
    chk({int_osc_sel, conv_run}, 16'h0002);
  endtask
  task automatic t_desel;
    u_adcms_host_model.frame({8'h00, CMD_ENTER_SLEEP, 1'b0}, 1, 1'b1);
    cyc(8);
    chk({analog_on, serial_out_ready_pin_oe_n}, 16'h0003);
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    trig_pin = 1'b0;
    conv_single = 1'b0;
    use_high_order_filter = 1'b0;
    delay_sel = 3'h0;
    cfg_settle_wr = 1'b0;
    conv_done = 1'b0;
    ext_clk_req = 1'b0;
    cyc(4);
    rst_n = 1'b1;
    cyc(4);
    t_reset;
    t_cont;
    t_single;
    t_sleep;
    t_reset_cmd;
    t_desel;
    give_verdict;
  end
  initial begin
    #400000;
    fails++;
    give_verdict;
  end
endmodule // adc_mode_sequencer_tb
`default_nettype wire

/* testbench/adcms_chk.sv */
// Purpose: Port-level assertions for the ADC mode sequencer.
// Assumes: Bound to every adcms_top instance.
// Notes:   All checks run on core_clk.
`timescale 1ns/1ps
`default_nettype none
module adcms_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic trig_pin,
  input wire logic conv_single,
  input wire logic use_high_order_filter,
  input wire logic conv_done,
  input wire logic data_ready_n,
  input wire logic serial_out_ready_pin_oe_n,
  input wire logic analog_on,
  input wire logic core_clk_en,
  input wire logic mod_clk_en,
  input wire logic filter_reset,
  input wire logic conv_run,
  input wire logic cal_cmd
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ====================================
  // Checks
  AST_OE_CS: assert property ((rst_n && $stable(cs_n)) [*5]
    |-> serial_out_ready_pin_oe_n == cs_n) else $error("pin enable not following select");
  AST_SLEEP_OFF: assert property (!analog_on |-> !mod_clk_en && !conv_run)
    else $error("activity while asleep");
  AST_STANDBY: assert property (!mod_clk_en && $past(rst_n)
    |-> !core_clk_en && filter_reset) else $error("standby not gated");
  AST_RUN: assert property (conv_run |-> mod_clk_en && core_clk_en && !filter_reset)
    else $error("converting with clocks gated");
  AST_TRIG: assert property ($rose(trig_pin) && analog_on |-> ##[2:8] mod_clk_en)
    else $error("trigger did not start");
  AST_TRIG_DATA_READY_N: assert property ($rose(trig_pin) && analog_on |-> ##[1:8] data_ready_n)
    else $error("ready not cleared by trigger");
  AST_SCLK_DATA_READY_N: assert property ($rose(sclk) && !cs_n |-> ##[1:6] data_ready_n)
    else $error("ready not cleared by serial clock");
  AST_DATA_READY_N_FALL: assert property ($fell(data_ready_n) |-> $past(conv_done))
    else $error("ready fell without a result");
  AST_SINGLE_END: assert property (conv_done && conv_run && conv_single
    && !use_high_order_filter |-> ##[1:2] !conv_run) else $error("single shot kept running");
  AST_CAL_RUN: assert property (cal_cmd |-> mod_clk_en || $past(mod_clk_en))
    else $error("calibration accepted in standby");
endmodule // adcms_chk
bind adcms_top adcms_chk u_chk (.*);
`default_nettype wire

/* testbench/adcms_host_model.sv */
// Purpose: Host controller on the serial link.
// Assumes: Mode 1 framing; clock runs only inside frames.
// Notes:   Released data line shows the inverse of its last bit.
`timescale 1ns/1ps
`default_nettype none
module adcms_host_model #(
  parameter int RESET_COMM_WAIT_NS = 2000
) (
  output var logic sclk,
  output var logic cs_n,
  output var logic din
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // Sends nb bytes MSB first; desel keeps chip select high throughout.
  task automatic frame(input logic [15:0] w, input int nb, input logic desel);
    logic [15:0] s;
    s = w << (8 * (2 - nb));
    #13;
    cs_n = desel;
    #40;
    for (int i = 0; i < 8 * nb; i++) begin
      sclk = 1'b1;
      din  = s[15];
      s    = s << 1;
      #40;
      sclk = 1'b0;
      #40;
    end
    cs_n = 1'b1;
    din  = ~din;
    if (w[7:1] == 7'h03) #(RESET_COMM_WAIT_NS);
  endtask
endmodule // adcms_host_model
`default_nettype wire
